// file: shared/store_map.vh
`ifndef STORE_MAP_VH
`define STORE_MAP_VH

// register byte offsets on the wishbone slave
`define OFF_CTRL 8'h00
`define OFF_BASE 8'h04
`define OFF_SIZE 8'h08
`define OFF_BASE_MIN 8'h0C
`define OFF_BASE_MAX 8'h10
`define OFF_SIZE_MIN 8'h14
`define OFF_SIZE_MAX 8'h18
`define OFF_STATUS 8'h1C
`define OFF_STORED 8'h20
`define OFF_RPT 8'h24
`define OFF_TRIG 8'h28

// address window limits, all in bytes of a24 space
`define BASE_MIN 24'h200000
`define BASE_MAX 24'hDFFFFC
`define SIZE_MIN 24'h000000
`define SIZE_MAX 24'hC00000
`define WINDOW_LIMIT 25'h0E00000

// reset values
`define BASE_RST 24'h200000
`define SIZE_RST 24'h000000
`define RPT_RST 24'h000001
`define TRIG_RST 24'h000001

// field positions
`define CTRL_EN_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_FULL_BIT 1
`define STAT_PLAN_BIT 2
`define STAT_CFG_BIT 3

// each reading is one 32-bit word, four bytes
`define WORD_BYTES 25'h0000004
`define WORD_SHIFT 2

// vme a24 non-privileged data access modifier
`define VME_AM_A24 6'h39

`endif

// file: hw/store_master.v
`include "store_map.vh"

module store_master (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire start_i,
    input wire [23:0] addr_i,
    input wire [31:0] data_i,
    output reg done_o,
    output reg [23:0] vme_addr_o,
    output reg [5:0] vme_am_o,
    output reg vme_write_n_o,
    output reg vme_as_n_o,
    output reg vme_ds_n_o,
    output reg [31:0] vme_data_o,
    output reg vme_data_oe_o,
    input wire vme_dtack_n_i
);

localparam [3:0] S_IDLE = 4'b0001;
localparam [3:0] S_SETUP = 4'b0010;
localparam [3:0] S_WAIT = 4'b0100;
localparam [3:0] S_REL = 4'b1000;

reg [3:0] state_reg;
reg dtack_meta_reg;
reg dtack_sync_reg;

////////////////////////////////////////////////////////////////////////////////
// dtack comes from the backplane, two flops before anything looks at it
always @(posedge clk_i) begin
    if (rst_i) begin
        dtack_meta_reg <= 1'b1;
        dtack_sync_reg <= 1'b1;
    end else if (ce_i) begin
        dtack_meta_reg <= vme_dtack_n_i;
        dtack_sync_reg <= dtack_meta_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// one write cycle per start; address and data settle a cycle before the strobes
always @(posedge clk_i) begin
    if (rst_i) begin
        state_reg <= S_IDLE;
        done_o <= 1'b0;
        vme_addr_o <= 24'h000000;
        vme_am_o <= 6'h00;
        vme_write_n_o <= 1'b1;
        vme_as_n_o <= 1'b1;
        vme_ds_n_o <= 1'b1;
        vme_data_o <= 32'h00000000;
        vme_data_oe_o <= 1'b0;
    end else if (ce_i) begin
        done_o <= 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (start_i) begin
                    vme_addr_o <= addr_i;
                    vme_am_o <= `VME_AM_A24;
                    vme_data_o <= data_i;
                    vme_write_n_o <= 1'b0;
                    vme_data_oe_o <= 1'b1;
                    state_reg <= S_SETUP;
                end
            end
            S_SETUP: begin
                vme_as_n_o <= 1'b0;
                vme_ds_n_o <= 1'b0;
                state_reg <= S_WAIT;
            end
            S_WAIT: begin
                // no timeout: a missing memory card hangs here until reset
                if (!dtack_sync_reg) begin
                    vme_as_n_o <= 1'b1;
                    vme_ds_n_o <= 1'b1;
                    state_reg <= S_REL;
                end
            end
            S_REL: begin
                // wait for the slave to let go so the next cycle starts clean
                if (dtack_sync_reg) begin
                    vme_write_n_o <= 1'b1;
                    vme_data_oe_o <= 1'b0;
                    done_o <= 1'b1;
                    state_reg <= S_IDLE;
                end
            end
            default: begin
                state_reg <= S_IDLE;
            end
        endcase
    end
end

endmodule // store_master

// file: hw/reading_store.v
// Notes on behaviour
// - readings stored as raw IEEE-754 32-bit words
// - base in 2097152..14680060, resets to minimum
// - window bytes 0..12582912, resets to zero
// - base plus window never above 14680064
// - readings times triggers within window over four
// - enable steers readings to memory, resets off
// - enable reads back as 1 or 0
// - base reads present, minimum and maximum values
// - window reads present, minimum and maximum values
`include "store_map.vh"

module reading_store #(
    parameter COUNT_W = 22
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [31:0] reading_data_i,
    input wire reading_valid_i,
    output reg reading_ready_o,
    output wire [23:0] vme_addr_o,
    output wire [5:0] vme_am_o,
    output wire vme_write_n_o,
    output wire vme_as_n_o,
    output wire vme_ds_n_o,
    output wire [31:0] vme_data_o,
    output wire vme_data_oe_o,
    input wire vme_dtack_n_i
);

// apply byte enables of a write to a stored value
function [31:0] merge_bytes;
    input [31:0] cur;
    input [31:0] wdat;
    input [3:0] sel;
    integer i;
    begin
        merge_bytes = cur;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                merge_bytes[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
    end
endfunction

reg enable_reg;
reg [23:0] base_reg;
reg [23:0] size_reg;
reg [23:0] rpt_reg;
reg [23:0] trig_reg;
reg cfg_err_reg;
reg [COUNT_W-1:0] count_reg;
reg busy_reg;
reg start_reg;
reg [31:0] word_reg;
reg [23:0] word_addr_reg;
reg [31:0] rd_next;

wire done;
wire req;
wire wr;
wire [31:0] base_cand;
wire [31:0] size_cand;
wire [31:0] ctrl_cand;
wire [31:0] stat_cand;
wire base_ok;
wire size_ok;
wire [47:0] plan_words;
wire plan_ok;
wire [24:0] used_bytes;
wire full;
wire take;
wire [23:0] addr_next;
wire [31:0] rpt_cand;
wire [31:0] trig_cand;

////////////////////////////////////////////////////////////////////////////////
// bus decode; a request is taken on its first cycle, ack follows one edge later
assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr = req & wb_we_i;
assign base_cand = merge_bytes({8'h00, base_reg}, wb_dat_i, wb_sel_i);
assign size_cand = merge_bytes({8'h00, size_reg}, wb_dat_i, wb_sel_i);
assign ctrl_cand = merge_bytes({31'h00000000, enable_reg}, wb_dat_i, wb_sel_i);
assign stat_cand = merge_bytes(32'h00000000, wb_dat_i, wb_sel_i);
// counts keep only the low 24 bits; the upper byte is dropped on purpose
assign rpt_cand = merge_bytes({8'h00, rpt_reg}, wb_dat_i, wb_sel_i);
assign trig_cand = merge_bytes({8'h00, trig_reg}, wb_dat_i, wb_sel_i);

// out-of-range or misaligned base is refused and the old value stays
assign base_ok = (base_cand[31:24] == 8'h00) && (base_cand[23:0] >= `BASE_MIN) &&
    (base_cand[23:0] <= `BASE_MAX) && (base_cand[1:0] == 2'b00) &&
    (({1'b0, base_cand[23:0]} + {1'b0, size_reg}) <= `WINDOW_LIMIT);
assign size_ok = (size_cand[31:24] == 8'h00) && (size_cand[23:0] <= `SIZE_MAX) &&
    (({1'b0, base_reg} + {1'b0, size_cand[23:0]}) <= `WINDOW_LIMIT);

// the planned burst must fit the window, else nothing is stored
assign plan_words = rpt_reg * trig_reg;
assign plan_ok = plan_words <= {26'h0000000, size_reg[23:`WORD_SHIFT]};

// window is full once another word would pass its end
assign used_bytes = {count_reg, 3'b000} >> (3 - `WORD_SHIFT);
assign full = (used_bytes + `WORD_BYTES) > {1'b0, size_reg};
assign take = reading_ready_o & reading_valid_i;
assign addr_next = base_reg + used_bytes[23:0];

////////////////////////////////////////////////////////////////////////////////
// register writes; a refused value leaves a sticky error, set wins over clear
always @(posedge clk_i) begin
    if (rst_i) begin
        enable_reg <= 1'b0;
        base_reg <= `BASE_RST;
        size_reg <= `SIZE_RST;
        rpt_reg <= `RPT_RST;
        trig_reg <= `TRIG_RST;
        cfg_err_reg <= 1'b0;
    end else if (ce_i) begin
        if (wr && wb_adr_i == `OFF_CTRL) begin
            enable_reg <= ctrl_cand[`CTRL_EN_BIT];
        end
        if (wr && wb_adr_i == `OFF_BASE && base_ok) begin
            base_reg <= base_cand[23:0];
        end
        if (wr && wb_adr_i == `OFF_SIZE && size_ok) begin
            size_reg <= size_cand[23:0];
        end
        if (wr && wb_adr_i == `OFF_RPT) begin
            rpt_reg <= rpt_cand[23:0];
        end
        if (wr && wb_adr_i == `OFF_TRIG) begin
            trig_reg <= trig_cand[23:0];
        end
        if ((wr && wb_adr_i == `OFF_BASE && !base_ok) || (wr && wb_adr_i == `OFF_SIZE && !size_ok)) begin
            cfg_err_reg <= 1'b1;
        end else if (wr && wb_adr_i == `OFF_STATUS && stat_cand[`STAT_CFG_BIT]) begin
            cfg_err_reg <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux; unmapped offsets read zero and ignore writes
always @* begin
    rd_next = 32'h00000000;
    case (wb_adr_i)
        `OFF_CTRL: rd_next[`CTRL_EN_BIT] = enable_reg;
        `OFF_BASE: rd_next[23:0] = base_reg;
        `OFF_SIZE: rd_next[23:0] = size_reg;
        `OFF_BASE_MIN: rd_next[23:0] = `BASE_MIN;
        `OFF_BASE_MAX: rd_next[23:0] = `BASE_MAX;
        `OFF_SIZE_MIN: rd_next[23:0] = `SIZE_MIN;
        `OFF_SIZE_MAX: rd_next[23:0] = `SIZE_MAX;
        `OFF_STATUS: begin
            rd_next[`STAT_BUSY_BIT] = busy_reg;
            rd_next[`STAT_FULL_BIT] = full;
            rd_next[`STAT_PLAN_BIT] = ~plan_ok;
            rd_next[`STAT_CFG_BIT] = cfg_err_reg;
        end
        `OFF_STORED: rd_next[COUNT_W-1:0] = count_reg;
        `OFF_RPT: rd_next[23:0] = rpt_reg;
        `OFF_TRIG: rd_next[23:0] = trig_reg;
        default: rd_next = 32'h00000000;
    endcase
end

// ack is a single-cycle pulse one edge after the request appears
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
        wb_ack_o <= req;
        if (req && !wb_we_i) begin
            wb_dat_o <= rd_next;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// store engine: one reading in flight at a time, so ready drops while busy
always @(posedge clk_i) begin
    if (rst_i) begin
        count_reg <= {COUNT_W{1'b0}};
        busy_reg <= 1'b0;
        start_reg <= 1'b0;
        word_reg <= 32'h00000000;
        word_addr_reg <= `BASE_RST;
        reading_ready_o <= 1'b0;
    end else if (ce_i) begin
        start_reg <= 1'b0;
        if (wr && wb_adr_i == `OFF_CTRL && ctrl_cand[`CTRL_EN_BIT] && !enable_reg) begin
            // a fresh enable restarts filling at the window base
            count_reg <= {COUNT_W{1'b0}};
        end else if (done) begin
            count_reg <= count_reg + 1'b1;
        end
        if (take) begin
            word_reg <= reading_data_i;
            word_addr_reg <= addr_next;
            start_reg <= 1'b1;
            busy_reg <= 1'b1;
        end else if (done) begin
            busy_reg <= 1'b0;
        end
        // ready is registered, so it lags config by a cycle; take blocks a double grab
        reading_ready_o <= enable_reg & plan_ok & ~full & ~busy_reg & ~take & ~done;
    end
end

////////////////////////////////////////////////////////////////////////////////
// backplane write cycles
store_master u_master (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(start_reg),
    .addr_i(word_addr_reg),
    .data_i(word_reg),
    .done_o(done),
    .vme_addr_o(vme_addr_o),
    .vme_am_o(vme_am_o),
    .vme_write_n_o(vme_write_n_o),
    .vme_as_n_o(vme_as_n_o),
    .vme_ds_n_o(vme_ds_n_o),
    .vme_data_o(vme_data_o),
    .vme_data_oe_o(vme_data_oe_o),
    .vme_dtack_n_i(vme_dtack_n_i)
);

endmodule // reading_store

// file: tb/vme_mem_model.sv
module vme_card (
    input wire logic clk_i,
    input wire logic as_n_i,
    input wire logic ds_n_i,
    input wire logic write_n_i,
    input wire logic [23:0] addr_i,
    input wire logic [31:0] data_i,
    input wire logic [3:0] wait_i,
    output logic dtack_n_o,
    output logic [23:0] last_addr_o,
    output logic [31:0] last_data_o,
    output logic [15:0] writes_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wcnt = 4'h0;
    initial dtack_n_o = 1'b1;
    initial writes_o = 16'h0000;
    // answer after wait_i cycles; dtack stays low until the strobes rise again
    always @(posedge clk_i) begin
        if (as_n_i || ds_n_i) begin
            dtack_n_o <= 1'b1;
            wcnt <= 4'h0;
        end else if (wcnt < wait_i) begin
            wcnt <= wcnt + 4'h1;
        end else if (dtack_n_o && !write_n_i) begin
            dtack_n_o <= 1'b0;
            last_addr_o <= addr_i;
            last_data_o <= data_i; // word kept bit for bit
            writes_o <= writes_o + 16'h0001;
        end
    end
endmodule // vme_card

// file: tb/reading_store_sva.sv
module reading_store_sva #(
    parameter COUNT_W = 22
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic reading_valid_i,
    input wire logic reading_ready_o,
    input wire logic [23:0] vme_addr_o,
    input wire logic [5:0] vme_am_o,
    input wire logic vme_write_n_o,
    input wire logic vme_as_n_o,
    input wire logic vme_ds_n_o,
    input wire logic [31:0] vme_data_o,
    input wire logic vme_data_oe_o,
    input wire logic vme_dtack_n_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // a frozen clock enable stalls everything, so checks pause with it
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);
    sequence take_s;
        reading_valid_i && reading_ready_o;
    endsequence
    sequence acked_s;
        !vme_as_n_o && !vme_dtack_n_i;
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_reply: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acked");
    a_ready_drop: assert property (take_s |=> !reading_ready_o)
        else $error("ready stayed high after a reading");
    a_start_write: assert property (take_s |-> ##[2:4] !vme_as_n_o)
        else $error("taken reading not written");
    a_write_only: assert property (!vme_as_n_o |-> !vme_write_n_o && vme_data_oe_o && vme_am_o == 6'h39)
        else $error("bus cycle not a driven write");
    a_word_hold: assert property (!vme_as_n_o && !$past(vme_as_n_o) |-> $stable(vme_data_o) && $stable(vme_addr_o))
        else $error("word or address moved in a cycle");
    a_addr_window: assert property (!vme_as_n_o |-> vme_addr_o[1:0] == 2'h0 && vme_addr_o >= 24'h200000
        && vme_addr_o <= 24'hDFFFFC)
        else $error("address outside store space");
    a_bus_idle: assert property (reading_ready_o |-> vme_as_n_o && vme_ds_n_o)
        else $error("ready during a bus cycle");
    a_strobe_release: assert property (acked_s |-> ##[1:5] vme_as_n_o)
        else $error("strobes held after dtack");
endmodule // reading_store_sva

bind reading_store reading_store_sva #(.COUNT_W(COUNT_W)) sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .reading_valid_i(reading_valid_i),
    .reading_ready_o(reading_ready_o), .vme_addr_o(vme_addr_o), .vme_am_o(vme_am_o),
    .vme_write_n_o(vme_write_n_o), .vme_as_n_o(vme_as_n_o), .vme_ds_n_o(vme_ds_n_o),
    .vme_data_o(vme_data_o), .vme_data_oe_o(vme_data_oe_o), .vme_dtack_n_i(vme_dtack_n_i));

// file: tb/reading_store_test.sv
`include "store_map.vh"
module reading_store_test;
timeunit 1ns;
timeprecision 100ps;
logic clk_i = 0, rst_i = 1, ce_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, reading_valid_i = 0;
logic [7:0] wb_adr_i = 8'h00;
logic [31:0] wb_dat_i = 32'h0, reading_data_i = 32'h0, wb_dat_o, vme_data_o, mem_data;
logic [3:0] wb_sel_i = 4'hF, mem_wait = 4'h0;
logic wb_ack_o, reading_ready_o, vme_write_n_o, vme_as_n_o, vme_ds_n_o, vme_data_oe_o, vme_dtack_n_i;
logic [23:0] vme_addr_o, mem_addr;
logic [5:0] vme_am_o;
logic [15:0] mem_writes;
logic [31:0] rv [7] = '{32'h0, 32'h200000, 32'h0, 32'h200000, 32'hDFFFFC, 32'h0, 32'hC00000};
logic [31:0] fv [4] = '{32'h3F800000, 32'hC0490FDB, 32'h7F800000, 32'h00000001};
int bad_count = 0;
int checks = 0;
////////////////////////////////////////
initial forever #10 clk_i = ~clk_i;
reading_store #(.COUNT_W(22)) dut (.clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .reading_data_i, .reading_valid_i, .reading_ready_o,
    .vme_addr_o, .vme_am_o, .vme_write_n_o, .vme_as_n_o, .vme_ds_n_o, .vme_data_o, .vme_data_oe_o,
    .vme_dtack_n_i);
vme_card mem (.clk_i, .as_n_i(vme_as_n_o), .ds_n_i(vme_ds_n_o), .write_n_i(vme_write_n_o),
    .addr_i(vme_addr_o), .data_i(vme_data_o), .wait_i(mem_wait), .dtack_n_o(vme_dtack_n_i),
    .last_addr_o(mem_addr), .last_data_o(mem_data), .writes_o(mem_writes));
////////////////////////////////////////
task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
        bad_count++;
        $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
endtask
// one classic cycle; request held until the edge that samples ack
task wb(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // no local limit: only the watchdog ends a wait for ack
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // ack comes one edge after the request is taken
    chk(32'(n), 32'h2);
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, d, 1'b1, q);
endtask
task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(a, 32'h0, 1'b0, q);
    chk(q, exp);
endtask
// offer one reading, then wait for the card to see its write
task push(input logic [31:0] d, input logic [23:0] a);
    logic [15:0] w0;
    int n;
    w0 = mem_writes;
    n = 0;
    reading_data_i <= d;
    reading_valid_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (reading_ready_o !== 1'b1 && n < 50);
    reading_valid_i <= 1'b0;
    while (mem_writes == w0 && n < 150) begin @(posedge clk_i); n++; end
    chk({8'h0, mem_addr}, {8'h0, a});
    chk(mem_data, d);
endtask
task idle_ready;
    repeat (8) @(posedge clk_i);
    chk({31'h0, reading_ready_o}, 32'h0);
endtask
task tally_and_finish;
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
////////////////////////////////////////
// whole run is a few hundred cycles, so this only cuts a hang
initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    tally_and_finish;
end
initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), rv[i]);
    wr(`OFF_BASE, 32'hE00000);
    rd(`OFF_BASE, 32'h200000);
    wr(`OFF_BASE, 32'h1FFFFC);
    rd(`OFF_BASE, 32'h200000);
    wr(`OFF_SIZE, 32'hC00004);
    rd(`OFF_SIZE, 32'h0);
    wr(`OFF_SIZE, 32'hC00000);
    rd(`OFF_SIZE, 32'hC00000);
    wr(`OFF_BASE, 32'h200004);
    rd(`OFF_BASE, 32'h200000);
    wr(`OFF_SIZE, 32'h4);
    wr(`OFF_BASE, 32'hDFFFFC);
    rd(`OFF_BASE, 32'hDFFFFC);
    wr(`OFF_SIZE, 32'h8);
    rd(`OFF_SIZE, 32'h4);
    wr(`OFF_BASE, 32'h800000);
    wr(`OFF_SIZE, 32'h10);
    wr(`OFF_RPT, 32'h2);
    wr(`OFF_TRIG, 32'h3);
    wr(`OFF_CTRL, 32'h1);
    rd(`OFF_CTRL, 32'h1);
    rd(`OFF_STATUS, 32'hC);
    idle_ready;
    wr(`OFF_TRIG, 32'h2);
    wr(`OFF_STATUS, 32'h8);
    rd(`OFF_STATUS, 32'h0);
    // fast then slower card answers
    for (int i = 0; i < 4; i++) begin
        mem_wait <= 4'(3 * i);
        push(fv[i], 24'h800000 + 24'(4 * i));
    end
    idle_ready;
    rd(`OFF_STORED, 32'h4);
    rd(`OFF_STATUS, 32'h2);
    wr(`OFF_CTRL, 32'h0);
    rd(`OFF_CTRL, 32'h0);
    wr(`OFF_SIZE, 32'h20);
    idle_ready;
    wr(`OFF_CTRL, 32'h1);
    push(32'h40400000, 24'h800000);
    // a second reset mid-run must bring back the defaults
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) rd(8'(4 * i), rv[i]);
    tally_and_finish;
end
endmodule // reading_store_test
